// >>> bench/bit_test_skip_decimal_adjust_tb.sv
`timescale 1ns/1ps
module bit_test_skip_decimal_adjust_tb;
  import btsd_pkg::*;
  logic i_clk = 0, i_reset_n = 0, i_ce = 1, i_instr_valid = 0, i_next_two_word = 0;
  logic i_ext_set_en = 0, i_carry = 0, i_half_carry_flag = 0;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0] i_file_data, i_index_base = 8'h00, i_w = 8'h00;
  logic [3:0] i_bank_select_register = 4'h0;
  logic o_busy, o_rd_en, o_discard, o_w_we, o_carry;
  logic [11:0] o_rd_addr;
  logic [7:0] o_w;
  integer seed = 32'hb227;
  int mismatches = 0, checks_done = 0, cycles = 0;
  btsd_core dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_next_two_word(i_next_two_word),
    .i_file_data(i_file_data), .i_bank_select_register(i_bank_select_register),
    .i_ext_set_en(i_ext_set_en), .i_index_base(i_index_base), .i_w(i_w), .i_carry(i_carry),
    .i_half_carry_flag(i_half_carry_flag), .o_busy(o_busy), .o_rd_en(o_rd_en),
    .o_rd_addr(o_rd_addr), .o_discard(o_discard), .o_w_we(o_w_we), .o_w(o_w), .o_carry(o_carry));
  btsd_mem_model mem_u (.i_clk(i_clk), .i_rd_en(o_rd_en), .i_rd_addr(o_rd_addr), .o_data(i_file_data));
  // The clock toggles every half period of 10 ns.
  always #10 i_clk = ~i_clk;
  // A hang is cut short well above the expected run of a few hundred cycles.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Expected data address of a file access.
  function automatic logic [11:0] exp_addr(input logic a, input logic [7:0] f);
    if (a) return {i_bank_select_register, f};
    if (f <= IDX_LIMIT) return i_ext_set_en ? {4'h0, f + i_index_base} : {4'h0, f};
    return {4'hf, f};
  endfunction : exp_addr
  // Expected carry and working register after a decimal adjust.
  function automatic logic [8:0] daa_exp(input logic [7:0] w, input logic c, input logic dc);
    logic [8:0] t;
    t = {1'b0, w};
    if (w[3:0] > BCD_MAX || dc) t = t + {5'h0, BCD_FIX};
    if (t[8:4] > {1'b0, BCD_MAX} || c) t = t + {1'b0, BCD_FIX, 4'h0};
    return {t[8] | c, t[7:0]};
  endfunction : daa_exp
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // One bit test; an adjust offered while busy must be ignored.
  task automatic skip(input logic [3:0] pfx, input logic [2:0] b, input logic a,
                      input logic [7:0] f, input logic two);
    logic [11:0] ad;
    logic [7:0] d;
    int n, want;
    ad = exp_addr(a, f);
    d = ad[7:0] ^ {ad[11:8], ad[3:0]};
    want = ((pfx == OPC_SKIP_SET) == d[b]) ? (two ? 2 : 1) : 0;
    n = 0;
    i_instr = {pfx, b, a, f};
    i_next_two_word = two;
    i_instr_valid = 1;
    @(posedge i_clk);
    #1;
    i_instr = OPC_DAA;
    chk({11'h0, o_rd_en}, 12'h1);
    chk(o_rd_addr, ad);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      #1;
      i_instr_valid = 0;
      chk({11'h0, o_w_we}, 12'h0);
      if (o_discard === 1'b1) n++;
      if (o_busy !== 1'b1) break;
    end
    chk(n[11:0], want[11:0]);
  endtask : skip
  // Reset, then adjusts back to back, a frozen cycle, and random bit tests.
  initial begin
    logic [7:0] w;
    logic [1:0] cd;
    repeat (4) @(posedge i_clk);
    #1;
    i_reset_n = 1;
    for (int i = 0; i < 40; i++) begin
      w = $random(seed);
      cd = $random(seed);
      if (i == 0) {w, cd} = {8'hce, 2'b00};
      if (i == 1) {w, cd} = {8'h99, 2'b11};
      i_w = w;
      {i_carry, i_half_carry_flag} = cd;
      i_instr = OPC_DAA;
      i_instr_valid = 1;
      @(posedge i_clk);
      #1;
      chk({2'h0, o_w_we, o_carry, o_w}, {3'h1, daa_exp(w, cd[1], cd[0])});
    end
    i_instr_valid = 0;
    @(posedge i_clk);
    #1;
    i_ce = 0;
    i_instr_valid = 1;
    @(posedge i_clk);
    #1;
    chk({11'h0, o_w_we}, 12'h0);
    i_instr_valid = 0;
    i_ce = 1;
    for (int i = 0; i < 120; i++) begin
      i_bank_select_register = $random(seed);
      i_ext_set_en = $random(seed);
      i_index_base = $random(seed);
      w = (i < 8) ? 8'h5e + i[1:0] : $random(seed);
      cd = $random(seed);
      skip(i[0] ? OPC_SKIP_SET : OPC_SKIP_CLR, $random(seed), cd[0], w, cd[1]);
    end
    end_of_test();
  end
endmodule : bit_test_skip_decimal_adjust_tb

// >>> bench/btsd_mem_model.sv
`timescale 1ns/1ps
// Data memory beside the decoder; it answers a read only in the strobe cycle.
module btsd_mem_model (
  input wire logic i_clk, // Core clock.
  input wire logic i_rd_en, // Read strobe from the decoder.
  input wire logic [11:0] i_rd_addr, // Read address.
  output logic [7:0] o_data // Byte returned to the decoder.
);
  logic [7:0] last_r = 8'h5a;
  // Remember the last byte handed out.
  always_ff @(posedge i_clk) begin
    if (i_rd_en) begin
      last_r <= o_data;
    end
  end
  // Off the strobe the bus shows the inverse of the last byte, so a late sample is caught.
  assign o_data = i_rd_en ? (i_rd_addr[7:0] ^ {i_rd_addr[11:8], i_rd_addr[3:0]}) : ~last_r;
endmodule : btsd_mem_model

// >>> verilog/btsd_core.sv
`timescale 1ns/1ps
// Summary of operation
// - Prefix 1011 tests a file bit and skips the next instruction if zero.
// - Prefix 1010 tests a file bit and skips the next instruction if one.
// - A taken skip discards the prefetched word and runs one no-operation cycle.
// - Skipping a two-word instruction costs four cycles, two no-operation cycles.
// - Access bit zero selects the access bank, one selects the bank register's bank.
// - Access bit zero with extended set treats addresses up to 95 as indexed.
// - Decimal adjust fixes the 8-bit working register in one single-cycle instruction.
// - Low nibble gets six added when above nine or half carry set.
module btsd_core
  import btsd_pkg::*;
(
  input wire logic i_clk, // Core clock.
  input wire logic i_reset_n, // Asynchronous active low reset.
  input wire logic i_ce, // Clock enable, freezes state when low.
  input wire logic i_instr_valid, // Instruction word presented this cycle.
  input wire logic [15:0] i_instr, // Instruction word.
  input wire logic i_next_two_word, // Prefetched next instruction is two words.
  input wire logic [7:0] i_file_data, // Data read from the addressed byte.
  input wire logic [3:0] i_bank_select_register, // Bank select register.
  input wire logic i_ext_set_en, // Extended instruction set enabled.
  input wire logic [7:0] i_index_base, // Indexed addressing base pointer low byte.
  input wire logic [7:0] i_w, // Working register value.
  input wire logic i_carry, // Carry flag.
  input wire logic i_half_carry_flag, // Half carry flag.
  output logic o_busy, // Decoder cannot accept an instruction.
  output logic o_rd_en, // File read strobe.
  output logic [11:0] o_rd_addr, // Full data address of the read.
  output logic o_discard, // Current cycle executes as a no-operation.
  output logic o_w_we, // Working register write strobe.
  output logic [7:0] o_w, // Adjusted working register value.
  output logic o_carry // Updated carry flag.
);
  // ****************************************
  // Decode
  // ****************************************
  btsd_state_e state_r;
  btsd_state_e state_nxt;
  logic [15:0] instr_r;
  logic two_word_r;
  logic is_clr;
  logic is_set;
  logic is_daa;
  logic acc_sel;
  logic [7:0] faddr;
  logic [7:0] idx_addr;
  logic [2:0] bit_sel;
  logic tested;
  logic skip;
  btsd_daa_if daa_bus ();

  // Decode the presented word only when idle; skip opcodes are bit-oriented.
  assign is_clr = i_instr[15:12] == OPC_SKIP_CLR;
  assign is_set = i_instr[15:12] == OPC_SKIP_SET;
  assign is_daa = i_instr == OPC_DAA;
  assign acc_sel = i_instr[ACC_SEL_POS];
  assign faddr = i_instr[7:0];
  // The indexed offset wraps inside bank zero; the carry out is dropped on purpose.
  assign idx_addr = faddr + i_index_base;
  assign bit_sel = instr_r[BIT_SEL_LSB +: 3];
  // Tested bit is the file data at the latched position.
  assign tested = i_file_data[bit_sel];
  assign skip = (instr_r[15:12] == OPC_SKIP_CLR) ? !tested : tested;

  // ****************************************
  // Sequencer
  // ****************************************
  // A skip costs one extra cycle, or two if the skipped word is a two-word instruction.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BTSD_IDLE: begin
        if (i_instr_valid && (is_clr || is_set)) begin
          state_nxt = BTSD_TEST;
        end
      end
      BTSD_TEST: begin
        state_nxt = skip ? BTSD_NOP1 : BTSD_IDLE;
      end
      BTSD_NOP1: begin
        state_nxt = two_word_r ? BTSD_NOP2 : BTSD_IDLE;
      end
      BTSD_NOP2: begin
        state_nxt = BTSD_IDLE;
      end
      default: begin
        state_nxt = BTSD_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= BTSD_IDLE;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // Latch the instruction and the size of the following word at issue.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      instr_r <= 16'h0000;
      two_word_r <= 1'b0;
    end else if (i_ce && state_r == BTSD_IDLE && i_instr_valid) begin
      instr_r <= i_instr;
      two_word_r <= i_next_two_word;
    end
  end

  // ****************************************
  // Addressing
  // ****************************************
  // Address formed at issue; file data is expected back on the next cycle.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_en <= 1'b0;
      o_rd_addr <= 12'h000;
    end else if (i_ce) begin
      o_rd_en <= state_r == BTSD_IDLE && i_instr_valid && (is_clr || is_set);
      if (acc_sel) begin
        o_rd_addr <= {i_bank_select_register, faddr};
      end else if (i_ext_set_en && faddr <= IDX_LIMIT) begin
        o_rd_addr <= {4'h0, idx_addr};
      end else if (faddr <= IDX_LIMIT) begin
        o_rd_addr <= {4'h0, faddr};
      end else begin
        o_rd_addr <= {4'hf, faddr};
      end
    end
  end

  // No-operation cycles replace the discarded words.
  assign o_discard = state_r == BTSD_NOP1 || state_r == BTSD_NOP2;
  assign o_busy = state_r != BTSD_IDLE;

  // ****************************************
  // Decimal adjust
  // ****************************************
  assign daa_bus.w_in = i_w;
  assign daa_bus.c_in = i_carry;
  assign daa_bus.dc_in = i_half_carry_flag;
  btsd_daa u_daa (
    .bus(daa_bus)
  );

  // Result registered in the issue cycle; only carry changes among the flags.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_w_we <= 1'b0;
      o_w <= W_RST;
      o_carry <= 1'b0;
    end else if (i_ce) begin
      o_w_we <= state_r == BTSD_IDLE && i_instr_valid && is_daa;
      if (state_r == BTSD_IDLE && i_instr_valid && is_daa) begin
        o_w <= daa_bus.w_out;
        o_carry <= daa_bus.c_out;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_skip_nop;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && state_r == BTSD_TEST && skip) |=> o_discard;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skip gave no nop");

  property p_noskip;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && state_r == BTSD_TEST && !skip) |=> !o_discard;
  endproperty
  a_noskip: assert property (p_noskip) else $error("nop without skip");

  property p_two_word;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && state_r == BTSD_NOP1 && two_word_r) |=> state_r == BTSD_NOP2;
  endproperty
  a_two_word: assert property (p_two_word) else $error("second nop missing");

  property p_one_word;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && state_r == BTSD_NOP1 && !two_word_r) |=> state_r == BTSD_IDLE;
  endproperty
  a_one_word: assert property (p_one_word) else $error("extra nop");

  property p_set_polarity;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && state_r == BTSD_TEST && instr_r[15:12] == OPC_SKIP_SET)
      |=> o_discard == $past(tested);
  endproperty
  a_set_polarity: assert property (p_set_polarity) else $error("set test wrong");

  property p_bank;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && state_r == BTSD_IDLE && i_instr_valid && is_clr && acc_sel)
      |=> o_rd_addr[11:8] == $past(i_bank_select_register);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");

  property p_daa_one_cycle;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && state_r == BTSD_IDLE && i_instr_valid && is_daa) |=> o_w_we && !o_busy;
  endproperty
  a_daa_one_cycle: assert property (p_daa_one_cycle) else $error("adjust not one cycle");

  property p_daa_low;
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_w_we && $past(i_ce) && $past(i_w[3:0]) <= BCD_MAX && !$past(i_half_carry_flag))
      |-> o_w[3:0] == $past(i_w[3:0]);
  endproperty
  a_daa_low: assert property (p_daa_low) else $error("low nibble changed");

  property p_carry_kept;
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_w_we && $past(i_ce) && $past(i_carry)) |-> o_carry;
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("carry lost");

  c_skip1: cover property (@(posedge i_clk) state_r == BTSD_NOP1 && !two_word_r);
  c_skip2: cover property (@(posedge i_clk) state_r == BTSD_NOP2);
  c_daa: cover property (@(posedge i_clk) o_w_we && o_carry);
endmodule : btsd_core

// >>> verilog/btsd_daa.sv
`timescale 1ns/1ps
module btsd_daa
  import btsd_pkg::*;
(
  btsd_daa_if.alu bus // Adjust operands and result.
);
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic lo_cy;
  // Low nibble gets six when above nine or half carry set; its carry feeds the high nibble.
  always_comb begin
    lo_sum = {1'b0, bus.w_in[3:0]};
    if (bus.w_in[3:0] > BCD_MAX || bus.dc_in) begin
      lo_sum = {1'b0, bus.w_in[3:0]} + {1'b0, BCD_FIX};
    end
    lo_cy = lo_sum[4];
    hi_sum = {1'b0, bus.w_in[7:4]} + {4'h0, lo_cy};
    if (hi_sum > {1'b0, BCD_MAX} || bus.c_in) begin
      hi_sum = hi_sum + {1'b0, BCD_FIX};
    end
  end
  assign bus.w_out = {hi_sum[3:0], lo_sum[3:0]};
  assign bus.c_out = bus.c_in | hi_sum[4];
endmodule : btsd_daa

// >>> verilog/btsd_if.sv
`timescale 1ns/1ps
// Carries the decimal adjust operands and result between the modules.
interface btsd_daa_if;
  logic [7:0] w_in;
  logic c_in;
  logic dc_in;
  logic [7:0] w_out;
  logic c_out;
  modport ctl (output w_in, output c_in, output dc_in, input w_out, input c_out);
  modport alu (input w_in, input c_in, input dc_in, output w_out, output c_out);
endinterface : btsd_daa_if

// >>> verilog/btsd_pkg.sv
package btsd_pkg;
  // Opcode prefixes and fields.
  localparam logic [3:0] OPC_SKIP_CLR = 4'hb;
  localparam logic [3:0] OPC_SKIP_SET = 4'ha;
  localparam logic [15:0] OPC_DAA = 16'h0007;
  localparam int BIT_SEL_LSB = 9;
  localparam int ACC_SEL_POS = 8;
  // Decimal adjust constants.
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  // Access bank indexed window upper bound.
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  // Reset values.
  localparam logic [7:0] W_RST = 8'h00;
  // Execution phases of the decoder.
  typedef enum logic [3:0] {
    BTSD_IDLE = 4'b0001,
    BTSD_TEST = 4'b0010,
    BTSD_NOP1 = 4'b0100,
    BTSD_NOP2 = 4'b1000
  } btsd_state_e;
endpackage : btsd_pkg
